/* hdl/touch_sensor_irq_logic.sv */
// What this block does
// - Interrupt pin is open drain, pulls low.
// - Three sources, each with enable and status.
// - Status read clears and releases pin at address.
// - Enabled stage completion asserts the pin.
// - Completion enable holds one bit per stage.
// - Completion status clears on read unless condition persists.
// - Touch mode interrupts on activation and on release.
// - Two registers of per-stage touch enables.
// - Two readable registers of per-stage touch status.
// - Touch interrupt holds until status is read.
// - Any touch status change asserts the pin.
// - Touch status read returns present activations.
// - Stage activated when result crosses a trip level.
// - Pin source enable sits in completion enable.
`timescale 1ns/1ns
`default_nettype none
module touch_sensor_irq_logic (
	input wire logic clk,
	input wire logic reset,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [11:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic [11:0] stage_done_i,
	input wire logic [11:0] stage_upper_trip_i,
	input wire logic [11:0] stage_lower_trip_i,
	input wire logic gpio_i,
	output logic int_o,
	output logic int_oe,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////////

	touch_irq_pkg::state_t s_q;
	touch_irq_pkg::state_t s_d;

	logic req;
	logic acc;
	logic rd_acc;
	logic wr_acc;
	logic [9:0] idx;
	logic req_rd_a;
	logic req_rd_b;
	logic req_rd_cd;
	logic [15:0] touch_now_a;
	logic [15:0] touch_now_b;
	logic chg_a;
	logic chg_b;
	logic gpio_cond;
	logic [15:0] cd_cond;
	logic [2:0] ev_set;
	logic [2:0] ev_clr;
	logic pin_a;
	logic pin_b;
	logic pin_cd;

	function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
		input logic [3:0] sel);
		logic [15:0] r;
		r = old;
		if (sel[0]) begin
			r[7:0] = wd[7:0];
		end
		if (sel[1]) begin
			r[15:8] = wd[15:8];
		end
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////

	assign req = cyc_i & stb_i;
	assign acc = req & ~s_q.ack;
	assign rd_acc = acc & ~we_i;
	assign wr_acc = acc & we_i;
	assign idx = adr_i[touch_irq_pkg::ADR_W-1:touch_irq_pkg::IDX_LSB];

	// The pin is released while a status read is merely addressed, before it is acked.
	assign req_rd_a = req & ~we_i & (idx == touch_irq_pkg::IDX_TOUCH_ST_A);
	assign req_rd_b = req & ~we_i & (idx == touch_irq_pkg::IDX_TOUCH_ST_B);
	assign req_rd_cd = req & ~we_i & (idx == touch_irq_pkg::IDX_CONV_ST);

	// Low trip results feed the first touch bank, high trip results the second.
	assign touch_now_a = touch_irq_pkg::REG_W'(stage_lower_trip_i) & s_q.en_a;
	assign touch_now_b = touch_irq_pkg::REG_W'(stage_upper_trip_i) & s_q.en_b;
	assign chg_a = touch_now_a != s_q.tch_a;
	assign chg_b = touch_now_b != s_q.tch_b;

	always_comb begin
		case (s_q.gpio_cfg)
			touch_irq_pkg::GPIO_NEG_LEVEL: gpio_cond = ~gpio_i;
			touch_irq_pkg::GPIO_POS_EDGE: gpio_cond = gpio_i & ~s_q.gpio_prev;
			touch_irq_pkg::GPIO_NEG_EDGE: gpio_cond = ~gpio_i & s_q.gpio_prev;
			touch_irq_pkg::GPIO_POS_LEVEL: gpio_cond = gpio_i;
			default: gpio_cond = 1'b0;
		endcase
	end

	always_comb begin
		cd_cond = touch_irq_pkg::REG_W'(stage_done_i);
		cd_cond[touch_irq_pkg::GPIO_BIT] = gpio_cond;
		cd_cond = cd_cond & s_q.cd_en;
	end

	always_comb begin
		ev_set = 3'h0;
		ev_set[touch_irq_pkg::EV_CONV] = |(touch_irq_pkg::REG_W'(stage_done_i) & s_q.cd_en);
		ev_set[touch_irq_pkg::EV_TOUCH] = chg_a | chg_b;
		ev_set[touch_irq_pkg::EV_GPIO] = cd_cond[touch_irq_pkg::GPIO_BIT];
		ev_clr = 3'h0;
		if (wr_acc && idx == touch_irq_pkg::IDX_EV_CLEAR && sel_i[0]) begin
			ev_clr = dat_i[touch_irq_pkg::EV_W-1:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	always_comb begin
		s_d = s_q;
		s_d.ack = acc;
		s_d.gpio_prev = gpio_i;
		if (rd_acc) begin
			case (idx)
				touch_irq_pkg::IDX_TOUCH_EN_A: s_d.rdat = 32'(s_q.en_a);
				touch_irq_pkg::IDX_TOUCH_EN_B: s_d.rdat = 32'(s_q.en_b);
				touch_irq_pkg::IDX_CONV_EN: s_d.rdat = 32'(s_q.cd_en);
				touch_irq_pkg::IDX_TOUCH_ST_A: s_d.rdat = 32'(touch_now_a);
				touch_irq_pkg::IDX_TOUCH_ST_B: s_d.rdat = 32'(touch_now_b);
				touch_irq_pkg::IDX_CONV_ST: s_d.rdat = 32'(s_q.cd_st);
				touch_irq_pkg::IDX_GPIO_CFG: s_d.rdat = 32'(s_q.gpio_cfg);
				touch_irq_pkg::IDX_EV_STATUS: s_d.rdat = 32'(s_q.ev_st);
				touch_irq_pkg::IDX_EV_ENABLE: s_d.rdat = 32'(s_q.ev_en);
				default: s_d.rdat = touch_irq_pkg::DATA_ZERO;
			endcase
		end
		if (wr_acc) begin
			case (idx)
				touch_irq_pkg::IDX_TOUCH_EN_A: s_d.en_a = lane_merge(s_q.en_a, dat_i, sel_i);
				touch_irq_pkg::IDX_TOUCH_EN_B: s_d.en_b = lane_merge(s_q.en_b, dat_i, sel_i);
				touch_irq_pkg::IDX_CONV_EN: s_d.cd_en = lane_merge(s_q.cd_en, dat_i, sel_i);
				touch_irq_pkg::IDX_GPIO_CFG: begin
					if (sel_i[0]) begin
						s_d.gpio_cfg = dat_i[touch_irq_pkg::GPIO_CFG_W-1:0];
					end
				end
				touch_irq_pkg::IDX_EV_ENABLE: begin
					if (sel_i[0]) begin
						s_d.ev_en = dat_i[touch_irq_pkg::EV_W-1:0];
					end
				end
				default: s_d.ev_en = s_q.ev_en;
			endcase
		end
		// A change in the very cycle of the read wins, so no edge of activity is lost.
		s_d.tch_a = touch_now_a;
		s_d.tch_b = touch_now_b;
		s_d.pend_a = chg_a | (s_q.pend_a & ~(rd_acc & req_rd_a));
		s_d.pend_b = chg_b | (s_q.pend_b & ~(rd_acc & req_rd_b));
		// A level that still holds simply sets the bit again after the clear.
		if (rd_acc && req_rd_cd) begin
			s_d.cd_st = cd_cond;
		end else begin
			s_d.cd_st = s_q.cd_st | cd_cond;
		end
		s_d.ev_st = ev_set | (s_q.ev_st & ~ev_clr);
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////

	assign pin_a = s_q.pend_a & ~req_rd_a;
	assign pin_b = s_q.pend_b & ~req_rd_b;
	assign pin_cd = (|s_q.cd_st) & ~req_rd_cd;
	assign int_o = 1'b0;
	assign int_oe = pin_a | pin_b | pin_cd;
	assign irq_o = |(s_q.ev_st & s_q.ev_en);
	assign ack_o = s_q.ack;
	assign dat_o = s_q.rdat;

	////////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);

	property p_ack_pulse;
		ack_o |=> !ack_o;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

	property p_pin_low;
		(s_q.pend_a && !req_rd_a) |-> (int_oe && !int_o);
	endproperty
	a_pin_low: assert property (p_pin_low) else $error("pending touch not on pin");

	property p_release;
		(req_rd_cd && !s_q.pend_a && !s_q.pend_b) |-> !int_oe;
	endproperty
	a_release: assert property (p_release) else $error("pin not released on read");

	property p_conv_set;
		(|(touch_irq_pkg::REG_W'(stage_done_i) & s_q.cd_en) && !req) |=>
			(|s_q.cd_st) && (int_oe || req_rd_cd);
	endproperty
	a_conv_set: assert property (p_conv_set) else $error("completion not flagged");

	property p_conv_clear;
		(rd_acc && req_rd_cd && cd_cond == touch_irq_pkg::REG_RESET)
			|=> (s_q.cd_st == touch_irq_pkg::REG_RESET);
	endproperty
	a_conv_clear: assert property (p_conv_clear) else $error("status not cleared");

	property p_touch_change;
		(touch_now_a != s_q.tch_a) |=> s_q.pend_a;
	endproperty
	a_touch_change: assert property (p_touch_change) else $error("change not pending");

	property p_touch_hold;
		(s_q.pend_a && !(rd_acc && req_rd_a)) |=> s_q.pend_a;
	endproperty
	a_touch_hold: assert property (p_touch_hold) else $error("touch pend dropped");

	property p_touch_read;
		(rd_acc && req_rd_a) |=> (dat_o[15:0] == $past(touch_now_a)) ##0 ack_o;
	endproperty
	a_touch_read: assert property (p_touch_read) else $error("touch read wrong");

	property p_other_read;
		(rd_acc && !req_rd_cd && cd_cond == touch_irq_pkg::REG_RESET)
			|=> (s_q.cd_st == $past(s_q.cd_st));
	endproperty
	a_other_read: assert property (p_other_read) else $error("status lost on read");

	property p_gpio_off;
		(!s_q.cd_en[touch_irq_pkg::GPIO_BIT] && !s_q.cd_st[touch_irq_pkg::GPIO_BIT])
			|=> !s_q.cd_st[touch_irq_pkg::GPIO_BIT];
	endproperty
	a_gpio_off: assert property (p_gpio_off) else $error("disabled gpio flagged");

	property p_drive_low;
		int_oe |-> (int_o == 1'b0);
	endproperty
	a_drive_low: assert property (p_drive_low) else $error("pin driven high");

	property p_pin_low_b;
		(s_q.pend_b && !req_rd_b) |-> int_oe;
	endproperty
	a_pin_low_b: assert property (p_pin_low_b) else $error("pending bank b not on pin");

	property p_pin_low_cd;
		((|s_q.cd_st) && !req_rd_cd) |-> int_oe;
	endproperty
	a_pin_low_cd: assert property (p_pin_low_cd) else $error("completion not on pin");

	property p_pin_idle;
		(!s_q.pend_a && !s_q.pend_b && s_q.cd_st == touch_irq_pkg::REG_RESET) |-> !int_oe;
	endproperty
	a_pin_idle: assert property (p_pin_idle) else $error("pin low with nothing pending");

	property p_release_a;
		(req_rd_a && !s_q.pend_b && s_q.cd_st == touch_irq_pkg::REG_RESET) |-> !int_oe;
	endproperty
	a_release_a: assert property (p_release_a) else $error("bank a read kept pin low");

	property p_release_b;
		(req_rd_b && !s_q.pend_a && s_q.cd_st == touch_irq_pkg::REG_RESET) |-> !int_oe;
	endproperty
	a_release_b: assert property (p_release_b) else $error("bank b read kept pin low");

	property p_clear_a;
		(rd_acc && req_rd_a && !chg_a) |=> !s_q.pend_a;
	endproperty
	a_clear_a: assert property (p_clear_a) else $error("bank a pend not cleared");

	property p_clear_b;
		(rd_acc && req_rd_b && !chg_b) |=> !s_q.pend_b;
	endproperty
	a_clear_b: assert property (p_clear_b) else $error("bank b pend not cleared");

	property p_touch_change_b;
		chg_b |=> s_q.pend_b;
	endproperty
	a_touch_change_b: assert property (p_touch_change_b) else $error("b change not pending");

	property p_touch_hold_b;
		(s_q.pend_b && !(rd_acc && req_rd_b)) |=> s_q.pend_b;
	endproperty
	a_touch_hold_b: assert property (p_touch_hold_b) else $error("bank b pend dropped");

	property p_touch_read_b;
		(rd_acc && req_rd_b) |=> (dat_o[15:0] == $past(touch_now_b)) && ack_o;
	endproperty
	a_touch_read_b: assert property (p_touch_read_b) else $error("bank b read wrong");

	property p_lower_trip;
		(|(touch_irq_pkg::REG_W'(stage_lower_trip_i) & s_q.en_a))
			|=> (|s_q.tch_a);
	endproperty
	a_lower_trip: assert property (p_lower_trip) else $error("lower trip not active");

	property p_upper_trip;
		(|(touch_irq_pkg::REG_W'(stage_upper_trip_i) & s_q.en_b))
			|=> (|s_q.tch_b);
	endproperty
	a_upper_trip: assert property (p_upper_trip) else $error("upper trip not active");

	property p_touch_off_a;
		(s_q.en_a == touch_irq_pkg::REG_RESET)
			|=> (s_q.tch_a == touch_irq_pkg::REG_RESET);
	endproperty
	a_touch_off_a: assert property (p_touch_off_a) else $error("disabled bank a active");

	property p_touch_off_b;
		(s_q.en_b == touch_irq_pkg::REG_RESET)
			|=> (s_q.tch_b == touch_irq_pkg::REG_RESET);
	endproperty
	a_touch_off_b: assert property (p_touch_off_b) else $error("disabled bank b active");

	property p_conv_off;
		(s_q.cd_en == touch_irq_pkg::REG_RESET && s_q.cd_st == touch_irq_pkg::REG_RESET)
			|=> (s_q.cd_st == touch_irq_pkg::REG_RESET);
	endproperty
	a_conv_off: assert property (p_conv_off) else $error("disabled stage flagged");

	property p_conv_sticky;
		!(rd_acc && req_rd_cd)
			|=> ((s_q.cd_st & $past(s_q.cd_st)) == $past(s_q.cd_st));
	endproperty
	a_conv_sticky: assert property (p_conv_sticky) else $error("completion bit lost");

	property p_conv_reload;
		(rd_acc && req_rd_cd) |=> (s_q.cd_st == $past(cd_cond));
	endproperty
	a_conv_reload: assert property (p_conv_reload) else $error("present condition lost");

	property p_conv_read;
		(rd_acc && req_rd_cd) |=> (dat_o[15:0] == $past(s_q.cd_st)) && ack_o;
	endproperty
	a_conv_read: assert property (p_conv_read) else $error("completion read wrong");

	property p_gpio_set;
		(s_q.cd_en[touch_irq_pkg::GPIO_BIT] && gpio_cond)
			|=> s_q.cd_st[touch_irq_pkg::GPIO_BIT];
	endproperty
	a_gpio_set: assert property (p_gpio_set) else $error("gpio event not flagged");

	property p_ack_follows;
		acc |=> ack_o;
	endproperty
	a_ack_follows: assert property (p_ack_follows) else $error("request not acked");

	property p_event_wins;
		(ev_set != 3'h0) |=> ((s_q.ev_st & $past(ev_set)) == $past(ev_set));
	endproperty
	a_event_wins: assert property (p_event_wins) else $error("event lost to clear");

	property p_irq_off;
		(s_q.ev_en == 3'h0) |-> !irq_o;
	endproperty
	a_irq_off: assert property (p_irq_off) else $error("irq with no enable");

endmodule
`default_nettype wire

/* hdl/touch_irq_pkg.sv */
`default_nettype none
package touch_irq_pkg;

	localparam int unsigned STAGE_NUM = 12;
	localparam int unsigned REG_W = 16;
	localparam int unsigned ADR_W = 12;
	localparam int unsigned IDX_W = 10;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned BYTE_W = 8;

	localparam logic [9:0] IDX_TOUCH_EN_A = 10'h005;
	localparam logic [9:0] IDX_TOUCH_EN_B = 10'h006;
	localparam logic [9:0] IDX_CONV_EN = 10'h007;
	localparam logic [9:0] IDX_TOUCH_ST_A = 10'h008;
	localparam logic [9:0] IDX_TOUCH_ST_B = 10'h009;
	localparam logic [9:0] IDX_CONV_ST = 10'h00a;
	localparam logic [9:0] IDX_GPIO_CFG = 10'h00b;
	localparam logic [9:0] IDX_EV_STATUS = 10'h00c;
	localparam logic [9:0] IDX_EV_CLEAR = 10'h00d;
	localparam logic [9:0] IDX_EV_ENABLE = 10'h00e;

	localparam int unsigned GPIO_BIT = 15;
	localparam int unsigned GPIO_CFG_W = 2;
	localparam logic [1:0] GPIO_NEG_LEVEL = 2'h0;
	localparam logic [1:0] GPIO_POS_EDGE = 2'h1;
	localparam logic [1:0] GPIO_NEG_EDGE = 2'h2;
	localparam logic [1:0] GPIO_POS_LEVEL = 2'h3;

	localparam int unsigned EV_W = 3;
	localparam int unsigned EV_CONV = 0;
	localparam int unsigned EV_TOUCH = 1;
	localparam int unsigned EV_GPIO = 2;

	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

	typedef struct packed {
		logic ack;
		logic [31:0] rdat;
		logic [15:0] en_a;
		logic [15:0] en_b;
		logic [15:0] cd_en;
		logic [15:0] cd_st;
		logic [15:0] tch_a;
		logic [15:0] tch_b;
		logic pend_a;
		logic pend_b;
		logic [1:0] gpio_cfg;
		logic gpio_prev;
		logic [2:0] ev_st;
		logic [2:0] ev_en;
	} state_t;

endpackage
`default_nettype wire

/* bench/host_int_model.sv */
`timescale 1ns/1ns
`default_nettype none
// The host sees the open-drain line through a pull-up, so a released pin reads high.
module host_int_model (
	input wire logic int_o,
	input wire logic int_oe,
	output logic int_n
);
	assign int_n = int_oe ? int_o : 1'b1;
endmodule
`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic clk, reset, cyc, stb, we, gpio, pin_n, pin_mid, ack, int_o, int_oe, irq;
	logic [11:0] adr, done, up, lo;
	logic [3:0] sel;
	logic [3:0] lanes;
	logic [31:0] wdat, rdat, rd_q;
	int err_count, checked;
	touch_sensor_irq_logic dut (.clk(clk), .reset(reset), .cyc_i(cyc), .stb_i(stb), .we_i(we),
		.adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack),
		.stage_done_i(done), .stage_upper_trip_i(up), .stage_lower_trip_i(lo), .gpio_i(gpio),
		.int_o(int_o), .int_oe(int_oe), .irq_o(irq));
	host_int_model host (.int_o(int_o), .int_oe(int_oe), .int_n(pin_n));
	////////////////////////////////////////////////////////////////////////////////
	task summarize;
		$display("errors %0d checks %0d", err_count, checked);
		if (err_count == 0 && checked > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// The pin is sampled halfway into the first cycle of the request, before ack can arrive.
	task xfer(input logic w, input logic [9:0] i, input logic [31:0] d);
		int n;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'h0};
		wdat <= d;
		sel <= lanes;
		@(negedge clk);
		pin_mid = pin_n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (ack !== 1'b1) begin
			err_count++;
			summarize();
		end
		rd_q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
		@(posedge clk);
	endtask
	task obs(input logic ep, input logic ei);
		@(negedge clk);
		chk({31'h0, pin_n}, {31'h0, ep});
		chk({31'h0, irq}, {31'h0, ei});
		@(posedge clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	initial begin
		repeat (5000) @(posedge clk);
		err_count++;
		summarize();
	end
	initial begin
		{reset, cyc, stb, we, adr, sel, wdat, done, up, lo} = '0;
		reset = 1'b1;
		gpio = 1'b1;
		lanes = 4'hf;
		err_count = 0;
		checked = 0;
		repeat (3) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		for (int i = 5; i <= 10; i++) begin
			xfer(1'b0, 10'(i), 32'h0);
			chk(rd_q, 32'h0);
		end
		xfer(1'b1, 10'h00a, 32'hffff);
		xfer(1'b0, 10'h00a, 32'h0);
		chk(rd_q, 32'h0);
		xfer(1'b1, 10'h007, 32'h8800);
		xfer(1'b0, 10'h007, 32'h0);
		chk(rd_q, 32'h8800);
		xfer(1'b1, 10'h005, 32'h0001);
		xfer(1'b1, 10'h006, 32'h0008);
		xfer(1'b0, 10'h006, 32'h0);
		chk(rd_q, 32'h0008);
		xfer(1'b1, 10'h00e, 32'h7);
		xfer(1'b0, 10'h3ff, 32'h0);
		chk(rd_q, 32'h0);
		done <= 12'h001;
		@(posedge clk);
		done <= 12'h0;
		obs(1'b1, 1'b0);
		done <= 12'h800;
		@(posedge clk);
		done <= 12'h0;
		obs(1'b0, 1'b1);
		xfer(1'b0, 10'h008, 32'h0);
		chk({31'h0, pin_mid}, 32'h0);
		xfer(1'b0, 10'h00a, 32'h0);
		chk(rd_q, 32'h0800);
		chk({31'h0, pin_mid}, 32'h1);
		xfer(1'b1, 10'h00d, 32'h7);
		obs(1'b1, 1'b0);
		lo <= 12'h001;
		@(posedge clk);
		obs(1'b0, 1'b1);
		xfer(1'b0, 10'h007, 32'h0);
		obs(1'b0, 1'b1);
		xfer(1'b0, 10'h008, 32'h0);
		chk(rd_q, 32'h0001);
		obs(1'b1, 1'b1);
		up <= 12'h008;
		@(posedge clk);
		obs(1'b0, 1'b1);
		xfer(1'b0, 10'h009, 32'h0);
		chk(rd_q, 32'h0008);
		lo <= 12'h0;
		up <= 12'h0;
		@(posedge clk);
		obs(1'b0, 1'b1);
		xfer(1'b0, 10'h008, 32'h0);
		chk(rd_q, 32'h0);
		xfer(1'b0, 10'h009, 32'h0);
		obs(1'b1, 1'b1);
		xfer(1'b1, 10'h00b, 32'h1);
		gpio <= 1'b0;
		@(posedge clk);
		obs(1'b1, 1'b1);
		gpio <= 1'b1;
		@(posedge clk);
		obs(1'b0, 1'b1);
		xfer(1'b0, 10'h00a, 32'h0);
		chk(rd_q, 32'h8000);
		xfer(1'b1, 10'h00d, 32'h7);
		obs(1'b1, 1'b0);
		xfer(1'b1, 10'h00b, 32'h3);
		obs(1'b0, 1'b1);
		xfer(1'b0, 10'h00b, 32'h0);
		chk(rd_q, 32'h3);
		xfer(1'b0, 10'h00a, 32'h0);
		chk(rd_q, 32'h8000);
		obs(1'b0, 1'b1);
		gpio <= 1'b0;
		xfer(1'b0, 10'h00a, 32'h0);
		chk(rd_q, 32'h8000);
		xfer(1'b1, 10'h00d, 32'h7);
		obs(1'b1, 1'b0);
		xfer(1'b1, 10'h00b, 32'h2);
		gpio <= 1'b1;
		@(posedge clk);
		obs(1'b1, 1'b0);
		gpio <= 1'b0;
		@(posedge clk);
		obs(1'b0, 1'b1);
		xfer(1'b0, 10'h00a, 32'h0);
		chk(rd_q, 32'h8000);
		obs(1'b1, 1'b1);
		xfer(1'b1, 10'h00b, 32'h0);
		obs(1'b0, 1'b1);
		xfer(1'b1, 10'h007, 32'h0800);
		xfer(1'b0, 10'h00a, 32'h0);
		chk(rd_q, 32'h8000);
		obs(1'b1, 1'b1);
		xfer(1'b0, 10'h00c, 32'h0);
		chk(rd_q, 32'h4);
		xfer(1'b0, 10'h00e, 32'h0);
		chk(rd_q, 32'h7);
		reset <= 1'b1;
		@(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		obs(1'b1, 1'b0);
		xfer(1'b0, 10'h007, 32'h0);
		chk(rd_q, 32'h0);
		lanes = 4'h2;
		xfer(1'b1, 10'h007, 32'h0880);
		lanes = 4'hf;
		xfer(1'b0, 10'h007, 32'h0);
		chk(rd_q, 32'h0800);
		summarize();
	end
endmodule
`default_nettype wire
